// >>> tape_check_defs.svh
// Constants for the cyclic check generator: bit positions and counts.
// Assumes inclusion by the package and the design modules.
`ifndef TAPE_CHECK_DEFS_SVH
`define TAPE_CHECK_DEFS_SVH
`define CHK_WIDTH 9
`define CHK_BIT_P 8
`define CHK_RESET_VALUE 9'h000
`define CHK_READOUT_MASK 9'h1EB
`define GAP_COUNT_WIDTH 2
`define GAP_COUNT_CLEAR 2'h0
`define GAP_COUNT_SHIFT 2'h1
`define GAP_COUNT_READOUT 2'h3
`define CHECK_SPACING 4
`endif

// >>> tape_check_pkg.sv
// Types shared by the cyclic check generator modules.
// Assumes tape_check_defs.svh is on the include path.
`include "tape_check_defs.svh"
package tape_check_pkg;
  typedef logic [`CHK_WIDTH-1:0] track_word_t;
  typedef logic [`GAP_COUNT_WIDTH-1:0] gap_count_t;
endpackage

// >>> gap_strobe_if.sv
// Strobes from the gap sequencer to the check register.
// Assumes one clock domain shared by both modules.
interface gap_strobe_if;
  logic extra_shift_strobe;
  logic readout_strobe;
  logic register_clear_strobe;
  logic gap_primer_flag;
  modport sequencer (output extra_shift_strobe, output readout_strobe,
    output register_clear_strobe, output gap_primer_flag);
  modport register (input extra_shift_strobe, input readout_strobe,
    input register_clear_strobe, input gap_primer_flag);
endinterface

// >>> gap_sequencer.sv
// Gap counter, primer flag and count decoder.
// Assumes gap clock and file-mark inputs are one-cycle pulses on CLK.
`include "tape_check_defs.svh"
module gap_sequencer
  import tape_check_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic gap_start,
  input wire logic gap_clock,
  input wire logic file_mark,
  gap_strobe_if.sequencer strobes
);
  gap_count_t count_ff;
  logic primer_ff;
  logic file_mark_ff;

  // Counter advances only while primed or away from zero
  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= `GAP_COUNT_CLEAR; // RL21
    end else if (gap_clock && (primer_ff || count_ff != `GAP_COUNT_CLEAR))
    begin
      count_ff <= count_ff + 2'h1; // RL15 RL16
    end
  end

  // Buffered file mark, released by the readout count
  always_ff @(posedge clk) begin
    if (reset) begin
      file_mark_ff <= 1'b0;
    end else if (file_mark) begin
      file_mark_ff <= 1'b1;
    end else if (gap_clock && count_ff == `GAP_COUNT_READOUT) begin
      file_mark_ff <= 1'b0;
    end
  end

  // Primer set at gap start or by a gap clock at count 0 after a buffered file mark, cleared by next gap clock
  always_ff @(posedge clk) begin
    if (reset) begin
      primer_ff <= 1'b0; // RL21
    end else if (gap_start) begin
      primer_ff <= 1'b1; // RL16
    end else if (gap_clock && file_mark_ff && !primer_ff &&
                 count_ff == `GAP_COUNT_CLEAR) begin
      primer_ff <= 1'b1; // RL16
    end else if (gap_clock) begin
      primer_ff <= 1'b0;
    end
  end

  always_comb begin
    strobes.extra_shift_strobe = gap_clock &&
      count_ff == `GAP_COUNT_SHIFT; // RL17
    strobes.readout_strobe = gap_clock &&
      count_ff == `GAP_COUNT_READOUT; // RL18
    strobes.register_clear_strobe = gap_clock && !primer_ff &&
      count_ff == `GAP_COUNT_CLEAR; // RL19
    strobes.gap_primer_flag = primer_ff;
  end
endmodule

// >>> tape_cyclic_check_generator.sv
// Cyclic check character generator for a nine-track incremental recorder.
// Assumes all strobes are single-cycle pulses synchronous to CLK.
`include "tape_check_defs.svh"
// Notes on behaviour
// [RL1] Check character written four steps after the last data character.
// [RL2] Longitudinal character four steps later, outside this block.
// [RL3] Nine-bit ring: P to 0, up to 7, 7 back to P.
// [RL4] Bits P,0,1,6,7 load data XOR preceding stage.
// [RL5] Bits 2 to 5 load data XOR preceding stage XOR bit 7.
// [RL6] Stages load only on a register clock, else hold.
// [RL7] Register cleared at tape load and in every gap.
// [RL8] One extra shift with zero data before readout.
// [RL9] Readout inverts every bit except 2 and 4.
// [RL10] Check character uses the same track order as data.
// [RL11] Outside gaps data passes through; readout disabled.
// [RL12] Register clock is the shutter or step phase two clock.
// [RL13] Write clock follows the shutter when no gap runs.
// [RL14] Data source ends records with a gap command.
// [RL15] Two-bit gap counter decodes counts 0, 1 and 3.
// [RL16] Counter holds at 0 until the primer flag is set.
// [RL17] Count 1 on second gap clock gives the extra shift.
// [RL18] Count 3 on fourth gap clock reads out and clocks write.
// [RL19] Count 0 with gap clock clears; suppressed while primed.
// [RL20] Inhibit after clear until a shutter clock from a write step.
// [RL21] Reset at tape load clears register, counter and flags.
module tape_cyclic_check_generator
  import tape_check_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [`CHK_WIDTH-1:0] DATA_IN,
  input wire logic SHUTTER_CLOCK,
  input wire logic STEP_PHASE_TWO_CLOCK,
  input wire logic USE_STEP_PHASE_CLOCK,
  input wire logic GAP_IN_PROCESS,
  input wire logic GAP_CLOCK,
  input wire logic FILE_MARK,
  output logic [`CHK_WIDTH-1:0] WRITE_DATA,
  output logic WRITE_AMP_CLOCK,
  output logic [`CHK_WIDTH-1:0] CHECK_REGISTER
);
  track_word_t check_shift_register;
  track_word_t nxt_check_shift_register;
  track_word_t stage_toggle;
  logic stage_p_ff;
  logic stage_0_ff;
  logic stage_1_ff;
  logic stage_2_ff;
  logic stage_3_ff;
  logic stage_4_ff;
  logic stage_5_ff;
  logic stage_6_ff;
  logic stage_7_ff;
  logic stage_clear;
  logic stage_load;
  track_word_t track_data;
  track_word_t cyclic_check_character;
  logic repeat_check_inhibit_flag_ff;
  logic gap_ff;
  logic gap_start;
  logic register_clock;
  logic readout_gated;
  logic [`CHK_WIDTH-1:0] write_data_ff;
  logic write_amp_clock_ff;

  gap_strobe_if strobes ();

  // Bit order in a word: [8]=P, [7:0]=bits 7..0
  function automatic track_word_t next_check(input track_word_t cur,
                                             input track_word_t din);
    track_word_t nxt;
    nxt = '0;
    nxt[`CHK_BIT_P] = din[`CHK_BIT_P] ^ cur[7]; // RL3 RL4
    nxt[0] = din[0] ^ cur[`CHK_BIT_P]; // RL4
    nxt[1] = din[1] ^ cur[0]; // RL4
    // Bit 7 feeds back into the middle four stages as well as into P
    nxt[2] = din[2] ^ cur[1] ^ cur[7]; // RL5
    nxt[3] = din[3] ^ cur[2] ^ cur[7]; // RL5
    nxt[4] = din[4] ^ cur[3] ^ cur[7]; // RL5
    nxt[5] = din[5] ^ cur[4] ^ cur[7]; // RL5
    nxt[6] = din[6] ^ cur[5]; // RL4
    nxt[7] = din[7] ^ cur[6]; // RL4
    return nxt;
  endfunction

  always_ff @(posedge CLK) begin
    if (RESET) begin
      gap_ff <= 1'b0;
    end else begin
      gap_ff <= GAP_IN_PROCESS;
    end
  end

  assign gap_start = GAP_IN_PROCESS && !gap_ff;

  gap_sequencer u_seq (
    .clk(CLK),
    .reset(RESET),
    .gap_start(gap_start),
    .gap_clock(GAP_CLOCK && GAP_IN_PROCESS),
    .file_mark(FILE_MARK && GAP_IN_PROCESS),
    .strobes(strobes)
  );

  // Data inputs forced to zero during gaps, so the extra shift sees zeros
  always_comb begin
    track_data = GAP_IN_PROCESS ? '0 : DATA_IN; // RL11 RL8
  end

  // Shutter-clocked or step-clocked variant
  always_comb begin
    register_clock = USE_STEP_PHASE_CLOCK ? STEP_PHASE_TWO_CLOCK
                                          : SHUTTER_CLOCK; // RL12
  end

  // Ring of nine stages, parity on top
  assign check_shift_register = {stage_p_ff, stage_7_ff, stage_6_ff,
    stage_5_ff, stage_4_ff, stage_3_ff, stage_2_ff, stage_1_ff, stage_0_ff};

  always_comb begin
    nxt_check_shift_register = next_check(check_shift_register,
                                          track_data);
  end

  // Toggle form: flipping by cur XOR next is a direct load of next
  always_comb begin
    stage_toggle = nxt_check_shift_register ^ check_shift_register; // RL6
  end

  // Clear beats any shift; extra shift only inside a gap
  always_comb begin
    stage_clear = strobes.register_clear_strobe; // RL7 RL19
    stage_load = strobes.extra_shift_strobe || // RL8 RL17
                 (register_clock && !GAP_IN_PROCESS); // RL6
  end

  always_comb begin
    cyclic_check_character = check_shift_register ^
                             `CHK_READOUT_MASK; // RL9
  end

  // Readout only after a primed count sequence and no repeat inhibit
  always_comb begin
    readout_gated = strobes.readout_strobe &&
                    !strobes.gap_primer_flag &&
                    !repeat_check_inhibit_flag_ff; // RL20
  end

  // Parity stage, fed from bit 7
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_p_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_p_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_p_ff <= stage_p_ff ^ stage_toggle[`CHK_BIT_P]; // RL3
    end else begin
      stage_p_ff <= stage_p_ff; // RL6
    end
  end

  // Bit 0 stage, fed from parity
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_0_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_0_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_0_ff <= stage_0_ff ^ stage_toggle[0]; // RL3
    end else begin
      stage_0_ff <= stage_0_ff; // RL6
    end
  end

  // Bit 1 stage, fed from bit 0
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_1_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_1_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_1_ff <= stage_1_ff ^ stage_toggle[1]; // RL3
    end else begin
      stage_1_ff <= stage_1_ff; // RL6
    end
  end

  // Bit 2 stage, fed from bit 1 and the bit 7 feedback
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_2_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_2_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_2_ff <= stage_2_ff ^ stage_toggle[2]; // RL5
    end else begin
      stage_2_ff <= stage_2_ff; // RL6
    end
  end

  // Bit 3 stage, fed from bit 2 and the bit 7 feedback
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_3_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_3_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_3_ff <= stage_3_ff ^ stage_toggle[3]; // RL5
    end else begin
      stage_3_ff <= stage_3_ff; // RL6
    end
  end

  // Bit 4 stage, fed from bit 3 and the bit 7 feedback
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_4_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_4_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_4_ff <= stage_4_ff ^ stage_toggle[4]; // RL5
    end else begin
      stage_4_ff <= stage_4_ff; // RL6
    end
  end

  // Bit 5 stage, fed from bit 4 and the bit 7 feedback
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_5_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_5_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_5_ff <= stage_5_ff ^ stage_toggle[5]; // RL5
    end else begin
      stage_5_ff <= stage_5_ff; // RL6
    end
  end

  // Bit 6 stage, fed from bit 5
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_6_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_6_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_6_ff <= stage_6_ff ^ stage_toggle[6]; // RL4
    end else begin
      stage_6_ff <= stage_6_ff; // RL6
    end
  end

  // Bit 7 stage, fed from bit 6; closes the ring
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stage_7_ff <= 1'b0; // RL21
    end else if (stage_clear) begin
      stage_7_ff <= 1'b0; // RL7
    end else if (stage_load) begin
      stage_7_ff <= stage_7_ff ^ stage_toggle[7]; // RL3
    end else begin
      stage_7_ff <= stage_7_ff; // RL6
    end
  end

  // Set by clear wins over a coincident shutter release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      repeat_check_inhibit_flag_ff <= 1'b0; // RL21
    end else if (strobes.register_clear_strobe) begin
      repeat_check_inhibit_flag_ff <= 1'b1; // RL20
    end else if (SHUTTER_CLOCK && !GAP_IN_PROCESS) begin
      repeat_check_inhibit_flag_ff <= 1'b0; // RL20
    end
  end

  // Check character goes out on the same track lines as data
  always_ff @(posedge CLK) begin
    if (RESET) begin
      write_data_ff <= '0;
    end else if (readout_gated) begin
      write_data_ff <= cyclic_check_character; // RL1 RL10 RL18
    end else begin
      write_data_ff <= track_data; // RL11
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      write_amp_clock_ff <= 1'b0;
    end else if (GAP_IN_PROCESS) begin
      // Longitudinal logic downstream spaces its character from this pulse
      write_amp_clock_ff <= readout_gated; // RL18 RL2
    end else begin
      write_amp_clock_ff <= SHUTTER_CLOCK; // RL13
    end
  end

  assign WRITE_DATA = write_data_ff;
  assign WRITE_AMP_CLOCK = write_amp_clock_ff;
  assign CHECK_REGISTER = check_shift_register;
endmodule

// >>> tape_cyclic_check_generator_sva.sv
// Port checker for the cyclic check generator.
// Assumes a bind onto the top module; one clock, sync reset.
module tape_check_sva (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [8:0] DATA_IN,
  input wire logic SHUTTER_CLOCK,
  input wire logic STEP_PHASE_TWO_CLOCK,
  input wire logic USE_STEP_PHASE_CLOCK,
  input wire logic GAP_IN_PROCESS,
  input wire logic GAP_CLOCK,
  input wire logic FILE_MARK,
  input wire logic [8:0] WRITE_DATA,
  input wire logic WRITE_AMP_CLOCK,
  input wire logic [8:0] CHECK_REGISTER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [2:0] cnt;
  logic spent;
  wire logic rclk = USE_STEP_PHASE_CLOCK ? STEP_PHASE_TWO_CLOCK
    : SHUTTER_CLOCK;
  wire logic gk = GAP_IN_PROCESS && GAP_CLOCK;
  function automatic logic [8:0] nx(logic [8:0] d, logic [8:0] r);
    logic [8:0] n;
    n = d ^ {r[7:0], r[8]};
    n[5:2] = n[5:2] ^ {4{r[7]}};
    return n;
  endfunction
  // Gap clocks seen in this gap, saturating
  always_ff @(posedge CLK) begin
    if (RESET || !GAP_IN_PROCESS) cnt <= 3'h0;
    else if (GAP_CLOCK && cnt != 3'h7) cnt <= cnt + 3'h1;
  end
  // Set by the gap clear, dropped by a step outside a gap
  always_ff @(posedge CLK) begin
    if (RESET) spent <= 1'h0;
    else if (gk && cnt == 3'h4) spent <= 1'h1;
    else if (!GAP_IN_PROCESS && SHUTTER_CLOCK) spent <= 1'h0;
  end
  property p_shift; !GAP_IN_PROCESS && rclk |=>
    CHECK_REGISTER == nx($past(DATA_IN), $past(CHECK_REGISTER)); endproperty
  a_shift: assert property (p_shift) else $error("bad shift");
  property p_hold; !GAP_IN_PROCESS && !rclk |=> $stable(CHECK_REGISTER); endproperty
  a_hold: assert property (p_hold) else $error("bad hold");
  property p_pass; !GAP_IN_PROCESS |=> WRITE_DATA == $past(DATA_IN)
    && WRITE_AMP_CLOCK == $past(SHUTTER_CLOCK); endproperty
  a_pass: assert property (p_pass) else $error("bad pass");
  property p_gapz; GAP_IN_PROCESS && !GAP_CLOCK |=>
    WRITE_DATA == 9'h000 && !WRITE_AMP_CLOCK; endproperty
  a_gapz: assert property (p_gapz) else $error("gap not quiet");
  property p_extra; gk && cnt == 3'h1 |=>
    CHECK_REGISTER == nx(9'h000, $past(CHECK_REGISTER)); endproperty
  a_extra: assert property (p_extra) else $error("no extra");
  property p_read; gk && cnt == 3'h3 && !spent |=> WRITE_AMP_CLOCK
    && WRITE_DATA == (CHECK_REGISTER ^ 9'h1EB); endproperty
  a_read: assert property (p_read) else $error("bad readout");
  property p_inhib; gk && spent |=> !WRITE_AMP_CLOCK; endproperty
  a_inhib: assert property (p_inhib) else $error("not inhibited");
  property p_clear; gk && cnt == 3'h4 |=> CHECK_REGISTER == 9'h000; endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_prime; gk && cnt == 3'h0 |=> $stable(CHECK_REGISTER); endproperty
  a_prime: assert property (p_prime) else $error("early clear");
  property p_reset; disable iff (1'h0) RESET |=> CHECK_REGISTER == 9'h000
    && WRITE_DATA == 9'h000 && !WRITE_AMP_CLOCK; endproperty
  a_reset: assert property (p_reset) else $error("bad reset");
endmodule

// >>> step_source.sv
// Data source model: write steps, gap commands and file marks.
// Assumes the bench clock; drives just after falling edges.
module step_source (
  input wire logic clk,
  output logic [8:0] data,
  output logic shutter,
  output logic phase2,
  output logic gap,
  output logic gclk,
  output logic fmark
);
  initial {data, shutter, phase2, gap, gclk, fmark} = '0;
  // Data differs at the phase-two pulse to tell the two clocks apart
  task automatic step(input logic [8:0] d);
    @(negedge clk) {data, shutter} = {d, 1'h1};
    @(negedge clk) {data, shutter, phase2} = {~d, 2'h1};
    @(negedge clk) {data, phase2} = {d, 1'h0};
  endtask
  task automatic end_record(input logic fm);
    @(negedge clk) gap = 1'h1;
    for (int i = 0; i < 12; i++) begin
      repeat (3) @(negedge clk);
      {gclk, fmark} = {1'h1, fm && i == 5};
      @(negedge clk) {gclk, fmark} = 2'h0;
    end
    @(negedge clk) gap = 1'h0;
  endtask
endmodule

// >>> tape_cyclic_check_generator_bench.sv
// Bench for the cyclic check generator, driven by the source model.
// Assumes design, checker and source are compiled before this file.
module tape_cyclic_check_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0, RESET = 1'h1, USE_STEP_PHASE_CLOCK = 1'h0;
  logic [8:0] DATA_IN, WRITE_DATA, CHECK_REGISTER, d, r, exp_q[$];
  logic SHUTTER_CLOCK, STEP_PHASE_TWO_CLOCK, GAP_IN_PROCESS, GAP_CLOCK;
  logic FILE_MARK, WRITE_AMP_CLOCK;
  int n_mismatch = 0, n_compared = 0, cycles = 0, seed = 32'hA3FBDF2B;
  always #5 CLK = ~CLK;
  tape_cyclic_check_generator i_dut (.CLK, .RESET, .DATA_IN,
    .SHUTTER_CLOCK, .STEP_PHASE_TWO_CLOCK, .USE_STEP_PHASE_CLOCK,
    .GAP_IN_PROCESS, .GAP_CLOCK, .FILE_MARK, .WRITE_DATA,
    .WRITE_AMP_CLOCK, .CHECK_REGISTER);
  step_source i_src (.clk(CLK), .data(DATA_IN), .shutter(SHUTTER_CLOCK),
    .phase2(STEP_PHASE_TWO_CLOCK), .gap(GAP_IN_PROCESS), .gclk(GAP_CLOCK),
    .fmark(FILE_MARK));
  function automatic logic [8:0] sh(logic [8:0] dd, logic [8:0] rr);
    logic [8:0] n;
    n = dd ^ {rr[7:0], rr[8]};
    n[5:2] = n[5:2] ^ {4{rr[7]}};
    return n;
  endfunction
  task automatic check(logic [8:0] e, logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
    else if (WRITE_AMP_CLOCK === 1'h1 && exp_q.size() == 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t unexpected write", $time);
    end
    else if (WRITE_AMP_CLOCK === 1'h1)
      check(exp_q.pop_front(), WRITE_DATA);
  end
  initial begin
    r = 9'h000;
    repeat (6) @(negedge CLK);
    RESET = 1'h0;
    check(9'h000, CHECK_REGISTER);
    for (int k = 0; k < 6; k++) begin
      USE_STEP_PHASE_CLOCK = k[0];
      repeat (k % 3 + 1) begin
        d = 9'($random(seed));
        exp_q.push_back(d);
        r = sh(k[0] ? ~d : d, r);
        i_src.step(d);
      end
      check(r, CHECK_REGISTER);
      exp_q.push_back(sh(9'h000, r) ^ 9'h1EB);
      r = 9'h000;
      i_src.end_record(k == 5);
      check(9'h000, CHECK_REGISTER);
      if (k == 3) i_src.end_record(1'h0);
    end
    repeat (4) @(negedge CLK);
    check(9'h000, 9'(exp_q.size()));
    stop_test();
  end
endmodule
bind tape_cyclic_check_generator tape_check_sva i_sva (.CLK, .RESET,
  .DATA_IN, .SHUTTER_CLOCK, .STEP_PHASE_TWO_CLOCK, .USE_STEP_PHASE_CLOCK,
  .GAP_IN_PROCESS, .GAP_CLOCK, .FILE_MARK, .WRITE_DATA,
  .WRITE_AMP_CLOCK, .CHECK_REGISTER);
